// ---- rtl/acp_hex_dec.sv ----
// Upper-case ASCII hex character to nibble decoder
`timescale 1ns/1ps
`default_nettype none
module acp_hex_dec
    import acp_pkg::*;
(
    input  wire logic [7:0] i_chr,
    output logic      [3:0] o_nib,
    output logic            o_ok
);
    // ========================================================================
    // Decode digits and A to F only
    always_comb begin
        o_ok  = 1'b0;
        o_nib = 4'h0;
        if (i_chr >= ACP_CHR_0 && i_chr <= ACP_CHR_9) begin
            o_ok  = 1'b1;
            o_nib = 4'(i_chr - ACP_CHR_0);
        end else if (i_chr >= ACP_CHR_A && i_chr <= ACP_CHR_F) begin
            o_ok  = 1'b1;
            o_nib = 4'(i_chr - ACP_CHR_AOFS);
        end
    end
endmodule
`default_nettype wire

// ---- rtl/acp_parser.sv ----
// ASCII command interpreter for a two-channel acquisition module
//
// Chosen here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE1: frames end with carriage return
// RULE2: match two-hex-digit station id
// RULE3: silent on wrong id or line error
// RULE4: name read silent on syntax error
// RULE5: bang answers accept, question mark rejects
// RULE6: line rate or checksum change needs jumper
// RULE7: configuring needs jumper, answers at 00
// RULE8: configure reply carries the new id
// RULE9: host sends type code 00
// RULE10: rate code 06 means 9600 bps
// RULE11: format 00 engineering units, no checksum
// RULE12: read config returns id,type,rate,format
// RULE13: keyword 1 calibrates channel offset
// RULE14: keyword 0 calibrates channel gain
// RULE15: host calibrates offset before gain
// RULE16: keyword M returns model string
// RULE17: keyword 5 sets channel enables
// RULE18: keyword 6 reports channel enables
// RULE19: configure carries five hex fields
// RULE20: rate codes 01 to 08 map rates
// RULE21: format byte reserved, checksum, data format
// RULE22: checksum is byte sum of characters
// RULE23: commit settings after reply is sent
// RULE24: new delimiter drops partial frame
module acp_parser
    import acp_pkg::*;
(
    input  wire logic        I_CLK,
    input  wire logic        I_RST_N,
    input  wire logic        I_WB_CYC,
    input  wire logic        I_WB_STB,
    input  wire logic        I_WB_WE,
    input  wire logic [7:0]  I_WB_ADR,
    input  wire logic [3:0]  I_WB_SEL,
    input  wire logic [31:0] I_WB_DAT,
    output logic      [31:0] O_WB_DAT,
    output logic             O_WB_ACK,
    input  wire logic        I_CFG_JUMPER,
    input  wire logic [7:0]  I_RX_DATA,
    input  wire logic        I_RX_VALID,
    input  wire logic        I_RX_ERR,
    output logic      [7:0]  O_TX_DATA,
    output logic             O_TX_VALID,
    input  wire logic        I_TX_READY,
    output logic             O_CAL_OFFSET,
    output logic             O_CAL_GAIN,
    output logic             O_CAL_CHAN,
    output logic      [7:0]  O_STATION_ID,
    output logic      [7:0]  O_LINE_RATE_CODE,
    output logic      [7:0]  O_FORMAT,
    output logic      [19:0] O_BAUD_DIV,
    output logic      [1:0]  O_CHAN_EN,
    output logic             O_NV_WR
);
    // ========================================================================
    // State
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_PARSE = 3'b001,
        ST_SEND  = 3'b011,
        ST_SUMH  = 3'b010,
        ST_SUML  = 3'b110,
        ST_TERM  = 3'b111,
        ST_CMT   = 3'b101
    } acp_st_t;

    typedef struct packed {
        acp_st_t          st;
        logic [15:0][7:0] rx, tx;
        logic [4:0]       rx_len, tx_len, tx_idx;
        logic             rx_act, rx_bad, tx_valid, commit, nv_wr, en, wb_ack;
        logic [7:0]       tx_sum, tx_data, addr, rate, fmt, p_addr, p_rate, p_fmt;
        logic [1:0]       chen, p_chen, jmp;
        logic [19:0]      div;
        logic             cal_off, cal_gain, cal_ch;
        logic [31:0]      wb_dat;
    } acp_state_t;

    acp_state_t s_reg;
    acp_state_t s_next;

    logic [15:0][3:0] nib;
    logic [15:0]      hv;
    logic [15:0][7:0] r_buf;
    logic [7:0]       eff_addr, rx_sum, r_addr, r_rate, r_fmt;
    logic [4:0]       body, r_len;
    logic [1:0]       r_chen;
    logic             jumper, ck_en, addr_ok, cks_ok, silent, ack;
    logic             r_commit, r_off, r_gain, cfg_chg;

    assign jumper   = s_reg.jmp[1];
    assign ck_en    = s_reg.fmt[ACP_FMT_CKS];
    assign eff_addr = jumper ? ACP_CFG_ADDR : s_reg.addr;  // [RULE7]

    function automatic logic [7:0] hex_chr(input logic [3:0] v);
        hex_chr = (v < 4'hA) ? (ACP_CHR_0 + {4'h0, v}) : (ACP_CHR_AOFS + {4'h0, v});
    endfunction

    // ========================================================================
    // Hex decode of every stored character
    for (genvar g = 0; g < 16; g++) begin : g_hex
        acp_hex_dec u_dec (
            .i_chr (s_reg.rx[g]),
            .o_nib (nib[g]),
            .o_ok  (hv[g])
        );
    end

    // ========================================================================
    // Command decode and reply build
    always_comb begin
        body = ck_en ? (s_reg.rx_len - ACP_LEN_CKS) : s_reg.rx_len;
        rx_sum = 8'h00;
        for (int i = 0; i < 16; i++) begin
            if (5'(i) < body) rx_sum = rx_sum + s_reg.rx[i];  // [RULE22]
        end
        cks_ok = !ck_en || (s_reg.rx_len > ACP_LEN_CKS + ACP_LEN_HDR
            && hv[body[3:0]] && hv[body[3:0] + 4'h1]
            && {nib[body[3:0]], nib[body[3:0] + 4'h1]} == rx_sum);  // [RULE22]
        addr_ok = body >= ACP_LEN_HDR && hv[1] && hv[2]
            && {nib[1], nib[2]} == eff_addr;  // [RULE2]
        silent   = !(addr_ok && cks_ok && s_reg.en && !s_reg.rx_bad);  // [RULE3]
        ack      = 1'b0;
        r_buf    = '0;
        r_len    = ACP_LEN_HDR;
        r_commit = 1'b0;
        r_off    = 1'b0;
        r_gain   = 1'b0;
        r_addr   = s_reg.addr;
        r_rate   = s_reg.rate;
        r_fmt    = s_reg.fmt;
        r_chen   = s_reg.chen;
        r_buf[1] = s_reg.rx[1];
        r_buf[2] = s_reg.rx[2];
        cfg_chg  = {nib[3], nib[4]} != s_reg.addr || {nib[7], nib[8]} != s_reg.rate
            || {nib[9], nib[10]} != s_reg.fmt;
        if (s_reg.rx[0] == ACP_CHR_PCT) begin
            // Configure: new id, type, rate code, format byte
            if (body == ACP_LEN_CFG && &hv[10:3]  // [RULE19]
                && {nib[7], nib[8]} >= ACP_RATE_MIN
                && {nib[7], nib[8]} <= ACP_RATE_MAX  // [RULE20]
                && nib[9][ACP_FMT_RSV - 4] == 1'b0
                && nib[10][1:0] != ACP_FMT_BAD  // [RULE21]
                && {nib[5], nib[6]} == ACP_TYPE
                && (jumper || !cfg_chg)) begin  // [RULE6] [RULE7]
                ack      = 1'b1;
                r_commit = 1'b1;
                r_addr   = {nib[3], nib[4]};
                r_rate   = {nib[7], nib[8]};
                r_fmt    = {nib[9], nib[10]};  // [RULE11]
                r_buf[1] = hex_chr(nib[3]);  // [RULE8]
                r_buf[2] = hex_chr(nib[4]);
            end
        end else if (s_reg.rx[0] == ACP_CHR_DOL) begin
            if (s_reg.rx[3] == ACP_KEY_RDCFG && body == ACP_LEN_RD) begin
                ack      = 1'b1;  // [RULE12]
                r_buf[3] = hex_chr(ACP_TYPE[7:4]);
                r_buf[4] = hex_chr(ACP_TYPE[3:0]);
                r_buf[5] = hex_chr(s_reg.rate[7:4]);  // [RULE10]
                r_buf[6] = hex_chr(s_reg.rate[3:0]);
                r_buf[7] = hex_chr(s_reg.fmt[7:4]);
                r_buf[8] = hex_chr(s_reg.fmt[3:0]);
                r_len    = ACP_LEN_HDR + 5'd6;
            end else if ((s_reg.rx[3] == ACP_KEY_OFS || s_reg.rx[3] == ACP_KEY_GAIN)
                && body == ACP_LEN_CAL
                && (s_reg.rx[4] == ACP_CHR_0 || s_reg.rx[4] == ACP_CHR_1)) begin
                ack    = 1'b1;
                r_off  = s_reg.rx[3] == ACP_KEY_OFS;  // [RULE13]
                r_gain = s_reg.rx[3] == ACP_KEY_GAIN;  // [RULE14]
            end else if (s_reg.rx[3] == ACP_KEY_NAME) begin
                if (body == ACP_LEN_RD) begin
                    ack   = 1'b1;  // [RULE16]
                    r_len = ACP_LEN_HDR + ACP_NAME_LEN;
                    for (int i = 0; i < 8; i++) r_buf[i + 3] = ACP_NAME[i];
                end else begin
                    silent = 1'b1;  // [RULE4]
                end
            end else if (s_reg.rx[3] == ACP_KEY_CHEN && body == ACP_LEN_CHEN
                && s_reg.rx[4] == ACP_CHR_0 && hv[5]) begin
                ack      = 1'b1;
                r_commit = 1'b1;
                r_chen   = nib[5][1:0];  // [RULE17]
            end else if (s_reg.rx[3] == ACP_KEY_CHST && body == ACP_LEN_RD) begin
                ack      = 1'b1;  // [RULE18]
                r_buf[3] = ACP_CHR_0;
                r_buf[4] = hex_chr({2'b00, s_reg.chen});
                r_len    = ACP_LEN_HDR + 5'd2;
            end
        end
        r_buf[0] = ack ? ACP_CHR_BANG : ACP_CHR_QM;  // [RULE5]
        if (!ack) r_len = ACP_LEN_HDR;
    end

    // ========================================================================
    // Next-state logic
    always_comb begin
        s_next          = s_reg;
        s_next.cal_off  = 1'b0;
        s_next.cal_gain = 1'b0;
        s_next.nv_wr    = 1'b0;
        s_next.jmp      = {s_reg.jmp[0], I_CFG_JUMPER};
        // Wishbone slave: ack one cycle after the strobe, write on the ack edge
        s_next.wb_ack = I_WB_CYC && I_WB_STB && !s_reg.wb_ack;
        s_next.wb_dat = 32'h0000_0000;
        if (I_WB_CYC && I_WB_STB && !s_reg.wb_ack) begin
            if (I_WB_ADR == ACP_REG_CFG) begin
                s_next.wb_dat = {s_reg.addr, ACP_TYPE, s_reg.rate, s_reg.fmt};
            end else if (I_WB_ADR == ACP_REG_CHEN) begin
                s_next.wb_dat = {30'h0, s_reg.chen};
            end else if (I_WB_ADR == ACP_REG_STAT) begin
                s_next.wb_dat = {27'h0, s_reg.commit, jumper, s_reg.st};
            end else if (I_WB_ADR == ACP_REG_CTRL) begin
                s_next.wb_dat = {31'h0, s_reg.en};
            end
        end
        if (I_WB_CYC && I_WB_STB && I_WB_WE && s_reg.wb_ack && I_WB_SEL[0]) begin
            if (I_WB_ADR == ACP_REG_CHEN) begin
                s_next.chen = I_WB_DAT[1:0];
            end else if (I_WB_ADR == ACP_REG_CTRL) begin
                s_next.en = I_WB_DAT[0];
            end
        end
        case (s_reg.st)
            ST_IDLE: begin
                if (I_RX_VALID) begin
                    if (I_RX_DATA == ACP_CHR_PCT || I_RX_DATA == ACP_CHR_DOL
                        || I_RX_DATA == ACP_CHR_HASH || I_RX_DATA == ACP_CHR_AT) begin
                        s_next.rx_act = 1'b1;  // [RULE24]
                        s_next.rx_bad = I_RX_ERR;
                        s_next.rx     = '0;
                        s_next.rx[0]  = I_RX_DATA;
                        s_next.rx_len = 5'd1;
                    end else if (s_reg.rx_act && I_RX_DATA == ACP_CHR_CR) begin
                        s_next.rx_act = 1'b0;  // [RULE1]
                        s_next.rx_bad = s_reg.rx_bad || I_RX_ERR;
                        s_next.st     = ST_PARSE;
                    end else if (s_reg.rx_act) begin
                        if (s_reg.rx_len == ACP_BUF_LEN) begin
                            s_next.rx_bad = 1'b1;
                        end else begin
                            s_next.rx[s_reg.rx_len[3:0]] = I_RX_DATA;
                            s_next.rx_len = s_reg.rx_len + 5'd1;
                        end
                        if (I_RX_ERR) s_next.rx_bad = 1'b1;
                    end
                end
            end
            ST_PARSE: begin
                s_next.st     = ST_IDLE;
                s_next.tx_idx = 5'd0;
                s_next.tx_sum = 8'h00;
                if (!silent) begin
                    s_next.st       = ST_SEND;
                    s_next.tx       = r_buf;
                    s_next.tx_len   = r_len;
                    s_next.commit   = r_commit;
                    s_next.p_addr   = r_addr;
                    s_next.p_rate   = r_rate;
                    s_next.p_fmt    = r_fmt;
                    s_next.p_chen   = r_chen;
                    s_next.cal_off  = r_off;
                    s_next.cal_gain = r_gain;
                    s_next.cal_ch   = s_reg.rx[4] == ACP_CHR_1;
                end
            end
            ST_SEND, ST_SUMH, ST_SUML, ST_TERM: begin
                if (s_reg.tx_valid && I_TX_READY) begin
                    s_next.tx_valid = 1'b0;
                    if (s_reg.st == ST_SEND) begin
                        s_next.tx_idx = s_reg.tx_idx + 5'd1;
                        if (s_reg.tx_idx + 5'd1 == s_reg.tx_len) begin
                            s_next.st = ck_en ? ST_SUMH : ST_TERM;  // [RULE22]
                        end
                    end else if (s_reg.st == ST_SUMH) begin
                        s_next.st = ST_SUML;
                    end else if (s_reg.st == ST_SUML) begin
                        s_next.st = ST_TERM;
                    end else begin
                        s_next.st = s_reg.commit ? ST_CMT : ST_IDLE;  // [RULE23]
                    end
                end else if (!s_reg.tx_valid) begin
                    s_next.tx_valid = 1'b1;
                    if (s_reg.st == ST_SEND) begin
                        s_next.tx_data = s_reg.tx[s_reg.tx_idx[3:0]];
                        s_next.tx_sum  = s_reg.tx_sum + s_reg.tx[s_reg.tx_idx[3:0]];
                    end else if (s_reg.st == ST_SUMH) begin
                        s_next.tx_data = hex_chr(s_reg.tx_sum[7:4]);
                    end else if (s_reg.st == ST_SUML) begin
                        s_next.tx_data = hex_chr(s_reg.tx_sum[3:0]);
                    end else begin
                        s_next.tx_data = ACP_CHR_CR;  // [RULE1]
                    end
                end
            end
            ST_CMT: begin
                s_next.addr   = s_reg.p_addr;  // [RULE23]
                s_next.rate   = s_reg.p_rate;
                s_next.fmt    = s_reg.p_fmt;
                s_next.chen   = s_reg.p_chen;
                s_next.div    = ACP_DIVS[3'(s_reg.p_rate - ACP_RATE_MIN)];  // [RULE20]
                s_next.commit = 1'b0;
                s_next.nv_wr  = 1'b1;
                s_next.st     = ST_IDLE;
            end
            default: s_next.st = ST_IDLE;
        endcase
    end

    // ========================================================================
    // State register
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            s_reg      <= '0;
            s_reg.st   <= ST_IDLE;
            s_reg.addr <= ACP_RST_ADDR;
            s_reg.rate <= ACP_RATE_9600;
            s_reg.fmt  <= ACP_RST_FMT;
            s_reg.chen <= ACP_RST_CHEN;
            s_reg.div  <= ACP_DIVS[3'(ACP_RATE_9600 - ACP_RATE_MIN)];
            s_reg.en   <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs
    assign O_WB_DAT         = s_reg.wb_dat;
    assign O_WB_ACK         = s_reg.wb_ack;
    assign O_TX_DATA        = s_reg.tx_data;
    assign O_TX_VALID       = s_reg.tx_valid;
    assign O_CAL_OFFSET     = s_reg.cal_off;
    assign O_CAL_GAIN       = s_reg.cal_gain;
    assign O_CAL_CHAN       = s_reg.cal_ch;
    assign O_STATION_ID     = s_reg.addr;
    assign O_LINE_RATE_CODE = s_reg.rate;
    assign O_FORMAT         = s_reg.fmt;
    assign O_BAUD_DIV       = s_reg.div;
    assign O_CHAN_EN        = s_reg.chen;
    assign O_NV_WR          = s_reg.nv_wr;

    // ========================================================================
    // Assertions
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);

    a_term_is_cr: assert property (s_reg.st == ST_TERM && s_reg.tx_valid // [RULE1]
        |-> s_reg.tx_data == ACP_CHR_CR) else $error("terminator not CR");
    a_id_mismatch: assert property (s_reg.st == ST_PARSE && !addr_ok // [RULE2]
        |=> s_reg.st == ST_IDLE && !s_reg.tx_valid) else $error("answered foreign id");
    a_silent_err: assert property (s_reg.st == ST_PARSE && s_reg.rx_bad // [RULE3]
        |=> s_reg.st == ST_IDLE) else $error("answered bad frame");
    a_lead_char: assert property (s_reg.st == ST_SEND && s_reg.tx_valid // [RULE5]
        && s_reg.tx_idx == 5'd0 |-> s_reg.tx_data == ACP_CHR_BANG
        || s_reg.tx_data == ACP_CHR_QM) else $error("bad lead char");
    a_cfg_locked: assert property (s_reg.st == ST_PARSE && !silent && !jumper // [RULE6]
        && s_reg.rx[0] == ACP_CHR_PCT && cfg_chg
        |=> s_reg.tx[0] == ACP_CHR_QM && !s_reg.commit) else $error("config without jumper");
    a_new_id: assert property (s_reg.st == ST_CMT // [RULE8]
        |=> s_reg.addr == $past(s_reg.p_addr) && O_NV_WR) else $error("commit lost");
    a_rate_9600: assert property (s_reg.rate == ACP_RATE_9600 // [RULE10]
        |-> s_reg.div == 20'(ACP_CLK_HZ / 9600)) else $error("9600 divisor wrong");
    a_cal_offset: assert property (O_CAL_OFFSET |-> s_reg.st == ST_SEND && !O_CAL_GAIN // [RULE13]
        ##1 !O_CAL_OFFSET) else $error("offset pulse");
    a_cal_gain: assert property (O_CAL_GAIN // [RULE14]
        |-> s_reg.st == ST_SEND ##1 !O_CAL_GAIN) else $error("gain pulse");
    a_commit_late: assert property (s_reg.st == ST_CMT // [RULE23]
        |-> $past(s_reg.st) == ST_TERM) else $error("commit before reply");
    a_cks_drop: assert property (s_reg.st == ST_PARSE && !cks_ok // [RULE22]
        |=> s_reg.st == ST_IDLE) else $error("bad checksum answered");
endmodule
`default_nettype wire

// ---- rtl/acp_pkg.sv ----
// Constants shared by the ASCII configuration command interpreter
package acp_pkg;

    // ========================================================================
    // Clock and line rates
    localparam int unsigned ACP_CLK_HZ = 100_000_000;
    localparam logic [19:0] ACP_DIVS [8] = '{
        20'(ACP_CLK_HZ / 300),   20'(ACP_CLK_HZ / 600),   20'(ACP_CLK_HZ / 1200),
        20'(ACP_CLK_HZ / 2400),  20'(ACP_CLK_HZ / 4800),  20'(ACP_CLK_HZ / 9600),
        20'(ACP_CLK_HZ / 19200), 20'(ACP_CLK_HZ / 38400)};
    localparam logic [7:0] ACP_RATE_MIN  = 8'h01;
    localparam logic [7:0] ACP_RATE_MAX  = 8'h08;
    localparam logic [7:0] ACP_RATE_9600 = 8'h06;

    // ========================================================================
    // Characters and command keywords
    localparam logic [7:0] ACP_CHR_CR    = 8'h0D;
    localparam logic [7:0] ACP_CHR_PCT   = 8'h25;
    localparam logic [7:0] ACP_CHR_DOL   = 8'h24;
    localparam logic [7:0] ACP_CHR_HASH  = 8'h23;
    localparam logic [7:0] ACP_CHR_AT    = 8'h40;
    localparam logic [7:0] ACP_CHR_BANG  = 8'h21;
    localparam logic [7:0] ACP_CHR_QM    = 8'h3F;
    localparam logic [7:0] ACP_CHR_0     = 8'h30;
    localparam logic [7:0] ACP_CHR_1     = 8'h31;
    localparam logic [7:0] ACP_CHR_9     = 8'h39;
    localparam logic [7:0] ACP_CHR_A     = 8'h41;
    localparam logic [7:0] ACP_CHR_F     = 8'h46;
    localparam logic [7:0] ACP_CHR_AOFS  = 8'h37;
    localparam logic [7:0] ACP_KEY_RDCFG = 8'h32;
    localparam logic [7:0] ACP_KEY_OFS   = 8'h31;
    localparam logic [7:0] ACP_KEY_GAIN  = 8'h30;
    localparam logic [7:0] ACP_KEY_NAME  = 8'h4D;
    localparam logic [7:0] ACP_KEY_CHEN  = 8'h35;
    localparam logic [7:0] ACP_KEY_CHST  = 8'h36;

    // ========================================================================
    // Frame lengths, field layout, defaults
    localparam logic [4:0] ACP_BUF_LEN  = 5'd16;
    localparam logic [4:0] ACP_LEN_CFG  = 5'd11;
    localparam logic [4:0] ACP_LEN_RD   = 5'd4;
    localparam logic [4:0] ACP_LEN_CAL  = 5'd5;
    localparam logic [4:0] ACP_LEN_CHEN = 5'd6;
    localparam logic [4:0] ACP_LEN_CKS  = 5'd2;
    localparam logic [4:0] ACP_LEN_HDR  = 5'd3;
    localparam int         ACP_FMT_CKS  = 6;
    localparam int         ACP_FMT_RSV  = 7;
    localparam logic [1:0] ACP_FMT_BAD  = 2'b11;
    localparam logic [7:0] ACP_CFG_ADDR = 8'h00;
    localparam logic [7:0] ACP_TYPE     = 8'h00;
    localparam logic [7:0] ACP_RST_ADDR = 8'h01;
    localparam logic [7:0] ACP_RST_FMT  = 8'h00;
    localparam logic [1:0] ACP_RST_CHEN = 2'b11;
    // Model string is arbitrary, sent first character first
    localparam logic [4:0] ACP_NAME_LEN = 5'd8;
    localparam logic [0:7][7:0] ACP_NAME = "ACQ2CH01";

    // ========================================================================
    // Register map (byte addresses)
    localparam logic [7:0] ACP_REG_CFG  = 8'h00;
    localparam logic [7:0] ACP_REG_CHEN = 8'h04;
    localparam logic [7:0] ACP_REG_STAT = 8'h08;
    localparam logic [7:0] ACP_REG_CTRL = 8'h0C;

endpackage

// ---- sim/acp_host_model.sv ----
// Host model on the serial character link
`timescale 1ns/1ps
`default_nettype none
module acp_host_model
    import acp_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic [7:0] i_tx_data,
    input  wire logic       i_tx_valid,
    output logic      [7:0] o_rx_data,
    output logic            o_rx_valid,
    output logic            o_tx_ready
);
    // =====
    // Reply capture, slow consumer
    string reply = "";
    bit    done  = 0;
    initial begin
        o_rx_data <= 8'h00;
        o_rx_valid <= 1'b0;
        o_tx_ready <= 1'b0;
    end
    // Ready only every other cycle
    always @(posedge i_clk) begin
        o_tx_ready <= ~o_tx_ready;
        if (i_tx_valid && o_tx_ready) begin
            if (i_tx_data == ACP_CHR_CR) done = 1;
            else reply = $sformatf("%s%c", reply, i_tx_data);
        end
    end
    // Send one command, terminator appended
    task automatic send(input string s);
        reply = "";
        done = 0;
        for (int i = 0; i <= s.len(); i++) begin
            @(posedge i_clk);
            o_rx_data <= (i == s.len()) ? ACP_CHR_CR : s[i];
            o_rx_valid <= 1'b1;
            @(posedge i_clk);
            o_rx_valid <= 1'b0;
            o_rx_data <= ~o_rx_data; // Released line changes
        end
    endtask
endmodule
`default_nettype wire

// ---- sim/acp_parser_bench.sv ----
// Self-checking bench for the command interpreter
`timescale 1ns/1ps
`default_nettype none
module acp_parser_bench
    import acp_pkg::*;
;
    // =====
    // Signals and instances
    logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, jmp = 0, err = 0, ack, txv, rxv, rdy;
    logic cal_o, cal_g, cal_c, nvw;
    logic [7:0] adr = 8'h00, txd, rxd, sid, lrc, fmt;
    logic [1:0] chen;
    logic [2:0] cal_seen = 3'h0;
    logic [3:0] nv_n = 4'h0;
    logic [19:0] div;
    logic [31:0] wd = 32'h0, rd, d;
    int mismatches = 0, comparisons = 0;
    always #5 clk = ~clk;
    acp_parser dut (.I_CLK(clk), .I_RST_N(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb),
        .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hF), .I_WB_DAT(wd), .O_WB_DAT(rd),
        .O_WB_ACK(ack), .I_CFG_JUMPER(jmp), .I_RX_DATA(rxd), .I_RX_VALID(rxv),
        .I_RX_ERR(err), .O_TX_DATA(txd), .O_TX_VALID(txv), .I_TX_READY(rdy),
        .O_CAL_OFFSET(cal_o), .O_CAL_GAIN(cal_g), .O_CAL_CHAN(cal_c), .O_STATION_ID(sid),
        .O_LINE_RATE_CODE(lrc), .O_FORMAT(fmt), .O_BAUD_DIV(div), .O_CHAN_EN(chen),
        .O_NV_WR(nvw));
    acp_host_model host (.i_clk(clk), .i_tx_data(txd), .i_tx_valid(txv),
        .o_rx_data(rxd), .o_rx_valid(rxv), .o_tx_ready(rdy));
    // Last calibration pulse and count of commit pulses
    always @(posedge clk) begin
        if (cal_o || cal_g) cal_seen <= {cal_o, cal_g, cal_c};
        if (nvw) nv_n <= nv_n + 4'h1;
    end
    // =====
    // Tasks
    task automatic finish_test();
        if (mismatches == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check_str(input string got, input string exp);
        comparisons++;
        if (got != exp) begin
            mismatches++;
            $display("[ERR] %0t reply %s expected %s", $time, got, exp);
        end
    endtask
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t read %h expected %h", $time, got, exp);
        end
    endtask
    // Command, then reply or silence; empty string means silence
    task automatic cmd(input string s, input string exp);
        host.send(s);
        for (int n = 0; n < 300 && !host.done; n++) @(posedge clk);
        repeat (3) @(posedge clk);
        check_str(host.reply, exp);
    endtask
    // Classic single Wishbone cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        {cyc, stb, we, adr, wd} <= {1'b1, 1'b1, w, a, v};
        do @(posedge clk); while (ack !== 1'b1);
        d = rd;
        {cyc, stb} <= 2'b00;
        @(posedge clk);
    endtask
    // =====
    // Main sequence and watchdog
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        check_word(32'(div), ACP_CLK_HZ / 9600);
        cmd("$012", "!01000600");
        cmd("$022", "");
        err <= 1'b1;
        cmd("$012", "");
        err <= 1'b0;
        cmd("$01M", "!01ACQ2CH01");
        cmd("$01M5", "");
        cmd("$01501", "!01");
        cmd("$016", "!0101");
        cmd("$0111", "!01");
        check_word({29'h0, cal_seen}, 32'h0000_0005);
        cmd("$0101", "!01");
        cmd("$0103", "?01");
        check_word({29'h0, cal_seen}, 32'h0000_0003);
        cmd("%0101000740", "?01");
        jmp <= 1'b1;
        repeat (4) @(posedge clk);
        cmd("%0022000800", "!22");
        check_word({sid, lrc, fmt, nv_n, 2'b00, chen}, 32'h2208_0021);
        check_word(32'(div), ACP_CLK_HZ / 38400);
        jmp <= 1'b0;
        repeat (4) @(posedge clk);
        cmd("$9$222", "!22000800");
        wb(1'b0, ACP_REG_CFG, 32'h0);
        check_word(d, 32'h22000800);
        wb(1'b1, ACP_REG_CHEN, 32'h2);
        cmd("$226", "!2202");
        jmp <= 1'b1;
        repeat (4) @(posedge clk);
        cmd("%0022000840", "!22");
        jmp <= 1'b0;
        repeat (4) @(posedge clk);
        cmd("$226BE", "!2202E7");
        cmd("$226BF", "");
        wb(1'b0, 8'h10, 32'h0);
        check_word(d, 32'h0);
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        finish_test();
    end
endmodule
`default_nettype wire
